// ### mss_map.svh
/*
 * Address map, field positions, codes and reset values of the four-axis
 * start sequencer. Definitions only; included by bare name.
 */
`ifndef MSS_MAP_SVH
`define MSS_MAP_SVH

// Axis count and APB address slicing
`define MSS_NAXIS        4
`define MSS_AW           9
`define MSS_AX_MSB       7
`define MSS_AX_LSB       6
`define MSS_OFF_MSB      5
`define MSS_OFF_LSB      0
`define MSS_REGION_BIT   8
`define MSS_OFF_LAST     6'h1C
`define MSS_ALIGN_MASK   6'h03

// Per-axis register offsets within a 0x40 window, axis n at n*0x40
`define MSS_OFF_MOVE     6'h00
`define MSS_OFF_ARC      6'h04
`define MSS_OFF_MODE     6'h08
`define MSS_OFF_ENV2     6'h0C
`define MSS_OFF_ENV5     6'h10
`define MSS_OFF_IRQEN    6'h14
`define MSS_OFF_CAUSE    6'h18
`define MSS_OFF_STATUS   6'h1C
`define MSS_ADDR_CMD     9'h100

// Mode value fields
`define MSS_KIND_MSB     7
`define MSS_KIND_LSB     0
`define MSS_MSY_MSB      19
`define MSS_MSY_LSB      18
`define MSS_AMASK_MSB    23
`define MSS_AMASK_LSB    20
`define MSS_KIND_ARC_CW  8'h64
`define MSS_KIND_LIN1    8'h61
`define MSS_KIND_INC     8'h41
`define MSS_MSY_SYNC     2'h2
`define MSS_MSY_STOP     2'h3

// Environment fields
`define MSS_OWN_STOP_COUNTS_BIT     29
`define MSS_SYI_MSB      21
`define MSS_SYI_LSB      20
`define MSS_SYO_MSB      19
`define MSS_SYO_LSB      16

// Command word fields
`define MSS_CMD_MSB      7
`define MSS_CMD_LSB      0
`define MSS_CAX_MSB      11
`define MSS_CAX_LSB      8
`define MSS_CMD_START    8'h51

// Operation condition codes
`define MSS_COND_IDLE    4'h0
`define MSS_COND_RUN     4'h1
`define MSS_COND_PREV    4'h2
`define MSS_COND_SYNC    4'h3
`define MSS_COND_STOP    4'h4

// Sync emit timing codes and event vector layout (9 events per axis)
`define MSS_NEV          9
`define MSS_SYO_CMP1     4'h1
`define MSS_SYO_CMP5     4'h5
`define MSS_SYO_ACC_S    4'h8
`define MSS_SYO_DEC_E    4'hB
`define MSS_EV_CMP_BASE  4
`define MSS_CAUSE_LSB    4
`define MSS_CAUSE_MSB    12

// Reset values
`define MSS_RST_WORD     32'h0000_0000
`define MSS_RST_NIB      4'h0

`endif

// ### mss_pkg.sv
/*
 * Types of the start sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package mss_pkg;
    // Per-axis run state
    typedef enum logic [0:0] {
        MSS_IDLE = 1'b0,
        MSS_RUN  = 1'b1
    } mss_run_e;
endpackage
`default_nettype wire

// ### mss_axis_if.sv
/*
 * Carrier between the register file and one axis sequencer.
 * Assumes both ends run on clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
interface mss_axis_if;
    // Configuration from the register file
    logic [31:0] pmv;
    logic [31:0] pip;
    logic [31:0] pmd;
    logic        own_stop_counts;
    logic [1:0]  sync_src;
    // Command and shared events
    logic        cmd_start;
    logic        done_in;
    logic [3:0]  stops;
    logic [3:0]  syncs;
    // Results of the axis
    logic        queue_full;
    logic [3:0]  cond;
    logic        start;
    logic        stop;
    logic [31:0] act_mv;
    logic [31:0] act_ip;
    logic [31:0] act_md;

    modport ctl (output pmv, pip, pmd, own_stop_counts, sync_src, cmd_start, done_in, stops, syncs,
                 input queue_full, cond, start, stop, act_mv, act_ip, act_md);
    modport axis (input pmv, pip, pmd, own_stop_counts, sync_src, cmd_start, done_in, stops, syncs,
                  output queue_full, cond, start, stop, act_mv, act_ip, act_md);
endinterface
`default_nettype wire

// ### mss_axis.sv
/*
 * One axis of the start sequencer: one-deep queue, start condition,
 * shift into the active registers, run tracking.
 * Assumes done_in is a one-cycle pulse from the pulse generator.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mss_map.svh"
module mss_axis #(
    parameter int unsigned AXIS = 0
) (
    // Clock and reset
    input wire logic   clk_sys,
    input wire logic   rst,
    // Register file side
    mss_axis_if.axis   ax
);
    mss_pkg::mss_run_e state_q;
    logic              queued_q;
    logic [3:0]        pend_q;
    logic              sync_seen_q;
    logic              dummy_q;

    // Decode of the queued mode value
    wire [7:0] kind     = ax.pmd[`MSS_KIND_MSB:`MSS_KIND_LSB];
    wire [1:0] start_timing_select      = ax.pmd[`MSS_MSY_MSB:`MSS_MSY_LSB];
    wire [3:0] amask    = ax.pmd[`MSS_AMASK_MSB:`MSS_AMASK_LSB];
    wire [3:0] own_bit  = 4'(1 << AXIS);
    wire       is_arc   = (kind == `MSS_KIND_ARC_CW);
    wire       q_dummy  = (kind == `MSS_KIND_INC) && (ax.pmv == `MSS_RST_WORD);
    wire       running  = (state_q == mss_pkg::MSS_RUN);
    wire       accept   = ax.cmd_start && !queued_q;
    // Stops only collected while running when own stop is allowed to count
    wire       collect  = ax.own_stop_counts || !running;
    wire [3:0] own_drop = ax.own_stop_counts ? `MSS_RST_NIB : own_bit;
    wire       sel_sync = ax.syncs[ax.sync_src];
    wire       ready    = (start_timing_select == `MSS_MSY_SYNC) ? sync_seen_q :
                          (start_timing_select == `MSS_MSY_STOP) ? (pend_q == `MSS_RST_NIB) : 1'b1;
    // Shift only when the previous step has completed
    wire       go       = queued_q && !running && ready;
    wire       finish   = running && (ax.done_in || dummy_q);
    wire [3:0] cond_d   = queued_q ? ((start_timing_select == `MSS_MSY_SYNC) ? `MSS_COND_SYNC :
                                      (start_timing_select == `MSS_MSY_STOP) ? `MSS_COND_STOP :
                                      running ? `MSS_COND_PREV : `MSS_COND_IDLE) :
                          running ? `MSS_COND_RUN : `MSS_COND_IDLE;

    // Run state machine
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= mss_pkg::MSS_IDLE;
        end else begin
            case (state_q)
                mss_pkg::MSS_IDLE: if (go) state_q <= mss_pkg::MSS_RUN;
                mss_pkg::MSS_RUN:  if (finish) state_q <= mss_pkg::MSS_IDLE;
                default:           state_q <= mss_pkg::MSS_IDLE;
            endcase
        end
    end

    // Queue flag and the collected start conditions
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            queued_q    <= 1'b0;
            pend_q      <= `MSS_RST_NIB;
            sync_seen_q <= 1'b0;
        end else if (accept) begin
            queued_q    <= 1'b1;
            pend_q      <= amask & ~own_drop;
            sync_seen_q <= 1'b0;
        end else begin
            queued_q    <= queued_q && !go;
            pend_q      <= collect ? (pend_q & ~ax.stops) : pend_q;
            sync_seen_q <= sync_seen_q || sel_sync;
        end
    end

    // Active registers load at the shift; dummies never start pulses
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ax.act_mv <= `MSS_RST_WORD;
            ax.act_ip <= `MSS_RST_WORD;
            ax.act_md <= `MSS_RST_WORD;
            dummy_q   <= 1'b0;
            ax.start  <= 1'b0;
            ax.stop   <= 1'b0;
            ax.cond   <= `MSS_COND_IDLE;
        end else begin
            if (go) begin
                ax.act_mv <= ax.pmv;
                ax.act_ip <= is_arc ? ax.pip : `MSS_RST_WORD;
                ax.act_md <= ax.pmd;
                dummy_q   <= q_dummy;
            end
            ax.start <= go && !q_dummy;
            ax.stop  <= finish;
            ax.cond  <= cond_d;
        end
    end

    assign ax.queue_full = queued_q;
endmodule // mss_axis
`default_nettype wire

// ### mss_top.sv
/*
 * Four-axis synchronous start sequencer with its APB register file,
 * internal sync generation and event capture.
 * Assumes done_in and ev_in come from logic on clk_sys as one-cycle pulses,
 * and an APB master that holds a request until pready.
 */
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "mss_map.svh"

// What this block does
// - same-axis chains run from pre-registers alone
// - step written while running waits, then launches
// - dummy is zero-move incremental, no pulses
// - kind 64h arc, 61h linear, 41h incremental
// - command low byte code, axis bits above
// - mode 003C0041h waits for X and Y stop
// - own stop cleared: wait for others' stop
// - dummy terminates at once after start
// - no stop-trigger: start at pre-register shift
// - unselected axes ignore the start command
// - own stop set: wait all, start together
// - select 10b sets condition 0011b
// - sync wait ends on chosen axis's pulse
// - each axis emits sync on one event
// - nine events on pins and cause register
// - select 11b sets 0100b, waits mask stops
// - mask one bit per axis, all awaited
// - own stop counts only when option set
// - sync source 00 X to 11 U
module mss_top (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // APB slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [31:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // Pulse generator side, four axes
    input  wire logic [3:0]   done_in,
    input  wire logic [35:0]  ev_in,
    output logic [3:0]        axis_start,
    output logic [3:0]        axis_stop,
    output logic [127:0]      act_move,
    output logic [127:0]      act_arc,
    output logic [127:0]      act_mode,
    // Event observation
    output logic [35:0]       evt_pins,
    output logic [3:0]        evt_irq
);
    localparam int NA = `MSS_NAXIS;
    localparam int NE = `MSS_NEV;

    // APB and event output state
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic [35:0] evt_pins_q;
    logic [3:0]  evt_irq_q;

    // Per-axis register file
    logic [31:0] pmv_q   [NA];
    logic [31:0] pip_q   [NA];
    logic [31:0] pmd_q   [NA];
    logic [31:0] env2_q  [NA];
    logic [31:0] env5_q  [NA];
    logic [31:0] irqen_q [NA];
    logic [31:0] cause_q [NA];
    logic [3:0]  cond_w  [NA];
    logic [3:0]  stops_w;
    logic [3:0]  syncs_w;
    logic [3:0]  sync_q;
    logic [3:0]  start_w;

    // Address decode
    wire [`MSS_AW-1:0] addr   = paddr[`MSS_AW-1:0];
    wire [1:0]  ax_sel   = addr[`MSS_AX_MSB:`MSS_AX_LSB];
    wire [5:0]  off      = addr[`MSS_OFF_MSB:`MSS_OFF_LSB];
    wire        cmd_hit  = (addr == `MSS_ADDR_CMD) && (paddr[31:`MSS_AW] == 23'h0);
    wire        ax_hit   = !addr[`MSS_REGION_BIT] && (paddr[31:`MSS_AW] == 23'h0) &&
                           ((off & `MSS_ALIGN_MASK) == 6'h00) && (off <= `MSS_OFF_LAST);
    wire        mapped   = cmd_hit || ax_hit;
    wire        fire     = psel && penable && pready_q;
    wire        wr_fire  = fire && pwrite && mapped;
    wire        cmd_wr   = wr_fire && cmd_hit;
    // Command word: code in low byte, axis selection above
    wire        cmd_go   = cmd_wr && (pwdata[`MSS_CMD_MSB:`MSS_CMD_LSB] == `MSS_CMD_START);
    wire [3:0]  cmd_axes = pwdata[`MSS_CAX_MSB:`MSS_CAX_LSB];

    // Read selection; the status word shows the live operation condition
    wire [31:0] rd_status = {28'h0, cond_w[ax_sel]};
    wire [31:0] rd_axis   = (off == `MSS_OFF_MOVE)  ? pmv_q[ax_sel]   :
                            (off == `MSS_OFF_ARC)   ? pip_q[ax_sel]   :
                            (off == `MSS_OFF_MODE)  ? pmd_q[ax_sel]   :
                            (off == `MSS_OFF_ENV2)  ? env2_q[ax_sel]  :
                            (off == `MSS_OFF_ENV5)  ? env5_q[ax_sel]  :
                            (off == `MSS_OFF_IRQEN) ? irqen_q[ax_sel] :
                            (off == `MSS_OFF_CAUSE) ? cause_q[ax_sel] : rd_status;
    wire [31:0] rd_word   = ax_hit ? rd_axis : `MSS_RST_WORD;

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= `MSS_RST_WORD;
        end else begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !mapped;
            prdata_q  <= (psel && penable && !pready_q && !pwrite) ? rd_word : `MSS_RST_WORD;
        end
    end

    genvar a;
    generate
        for (a = 0; a < NA; a++) begin : g_ax
            wire        wr_ax  = wr_fire && ax_hit && (ax_sel == 2'(a));
            wire [NE-1:0] ev   = ev_in[a*NE +: NE];
            wire [3:0]  sync_emit_timing    = env5_q[a][`MSS_SYO_MSB:`MSS_SYO_LSB];
            // Enabled events only latch into the cause bits
            wire [NE-1:0] ev_set = ev & irqen_q[a][`MSS_CAUSE_MSB:`MSS_CAUSE_LSB];
            wire [NE-1:0] ev_clr = (wr_ax && off == `MSS_OFF_CAUSE) ?
                                   pwdata[`MSS_CAUSE_MSB:`MSS_CAUSE_LSB] : {NE{1'b0}};
            logic sync_d;
            mss_axis_if ifc ();

            // Host-written pre-registers and configuration
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    pmv_q[a]   <= `MSS_RST_WORD;
                    pip_q[a]   <= `MSS_RST_WORD;
                    pmd_q[a]   <= `MSS_RST_WORD;
                    env2_q[a]  <= `MSS_RST_WORD;
                    env5_q[a]  <= `MSS_RST_WORD;
                    irqen_q[a] <= `MSS_RST_WORD;
                end else if (wr_ax) begin
                    if (off == `MSS_OFF_MOVE)  pmv_q[a]   <= pwdata;
                    if (off == `MSS_OFF_ARC)   pip_q[a]   <= pwdata;
                    if (off == `MSS_OFF_MODE)  pmd_q[a]   <= pwdata;
                    if (off == `MSS_OFF_ENV2)  env2_q[a]  <= pwdata;
                    if (off == `MSS_OFF_ENV5)  env5_q[a]  <= pwdata;
                    if (off == `MSS_OFF_IRQEN) irqen_q[a] <= pwdata;
                end
            end

            // Write-one-to-clear cause; a new event wins over its clear
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    cause_q[a] <= `MSS_RST_WORD;
                end else begin
                    cause_q[a][`MSS_CAUSE_MSB:`MSS_CAUSE_LSB] <=
                        (cause_q[a][`MSS_CAUSE_MSB:`MSS_CAUSE_LSB] & ~ev_clr) | ev_set;
                end
            end

            // Exactly one event feeds the sync pulse; other codes emit nothing
            always_comb begin
                sync_d = 1'b0;
                if (sync_emit_timing >= `MSS_SYO_CMP1 && sync_emit_timing <= `MSS_SYO_CMP5) begin
                    sync_d = ev[`MSS_EV_CMP_BASE + 32'(sync_emit_timing - `MSS_SYO_CMP1)];
                end else if (sync_emit_timing >= `MSS_SYO_ACC_S && sync_emit_timing <= `MSS_SYO_DEC_E) begin
                    sync_d = ev[32'(sync_emit_timing - `MSS_SYO_ACC_S)];
                end
            end

            // Sync pulse, pins and summary flag are registered
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    sync_q[a]              <= 1'b0;
                    evt_pins_q[a*NE +: NE] <= {NE{1'b0}};
                    evt_irq_q[a]           <= 1'b0;
                end else begin
                    sync_q[a]              <= sync_d;
                    evt_pins_q[a*NE +: NE] <= ev;
                    evt_irq_q[a]           <= |cause_q[a];
                end
            end

            // Axis hookup; commands reach only the selected axes
            assign ifc.pmv             = pmv_q[a];
            assign ifc.pip             = pip_q[a];
            assign ifc.pmd             = pmd_q[a];
            assign ifc.own_stop_counts = env2_q[a][`MSS_OWN_STOP_COUNTS_BIT];
            assign ifc.sync_src        = env5_q[a][`MSS_SYI_MSB:`MSS_SYI_LSB];
            assign ifc.cmd_start       = cmd_go && cmd_axes[a];
            assign ifc.done_in         = done_in[a];
            assign ifc.stops           = stops_w;
            assign ifc.syncs           = syncs_w;
            assign cond_w[a]           = ifc.cond;
            assign stops_w[a]          = ifc.stop;
            assign start_w[a]          = ifc.start;
            assign act_move[a*32 +: 32] = ifc.act_mv;
            assign act_arc[a*32 +: 32]  = ifc.act_ip;
            assign act_mode[a*32 +: 32] = ifc.act_md;

            mss_axis #(
                .AXIS (a)
            ) u_axis (
                .clk_sys (clk_sys),
                .rst     (rst),
                .ax      (ifc.axis)
            );
        end
    endgenerate

    // Shared sync vector; one register stage keeps axis loops short
    assign syncs_w    = sync_q;
    assign axis_start = start_w;
    assign axis_stop  = stops_w;
    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign evt_pins   = evt_pins_q;
    assign evt_irq    = evt_irq_q;
endmodule // mss_top
`default_nettype wire

// ### mss_top_assertions.sv
/*
 * Port checker of the start sequencer, bound to mss_top at the foot.
 * Assumes one clock domain and a master that holds requests until pready.
 */
`timescale 1ns/1ps
`default_nettype none
module mss_top_assertions (
    // Clock and reset
    input wire logic         clk_sys,
    input wire logic         rst,
    // APB
    input wire logic         psel,
    input wire logic         penable,
    input wire logic [31:0]  prdata,
    input wire logic         pready,
    input wire logic         pslverr,
    // Axis side
    input wire logic [3:0]   done_in,
    input wire logic [35:0]  ev_in,
    input wire logic [3:0]   axis_start,
    input wire logic [3:0]   axis_stop,
    input wire logic [127:0] act_move,
    input wire logic [127:0] act_arc,
    input wire logic [127:0] act_mode,
    input wire logic [35:0]  evt_pins
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Exactly one wait state, then a single answer cycle
    sequence one_wait_s;
        !pready ##1 pready;
    endsequence

    apb_wait_a: assert property ($rose(psel && penable) |-> one_wait_s ##1 !pready)
        else $error("pready not one wait state");
    err_ready_a: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside answer");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero when idle");
    evt_copy_a: assert property (!$past(rst) |-> evt_pins == $past(ev_in))
        else $error("event pins not a one cycle copy");

    // Per axis: launches, dummies and stops
    for (genvar i = 0; i < 4; i++) begin : g_ax
        dummy_quiet_a: assert property (axis_start[i] |->
            !(act_mode[32*i+:8] == 8'h41 && act_move[32*i+:32] == 32'h0000_0000))
            else $error("dummy step launched pulses");
        arc_zero_a: assert property (act_arc[32*i+:32] != 32'h0000_0000 |-> act_mode[32*i+:8] == 8'h64)
            else $error("arc loaded for a non arc kind");
        stop_cause_a: assert property (axis_stop[i] &&
            !(act_mode[32*i+:8] == 8'h41 && act_move[32*i+:32] == 32'h0000_0000) |-> $past(done_in[i]))
            else $error("real step stopped without completion");
        start_pulse_a: assert property (axis_start[i] |=> !axis_start[i] && !axis_stop[i])
            else $error("launch pulse too long");
    end
endmodule // mss_top_assertions

bind mss_top mss_top_assertions u_chk (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .done_in(done_in), .ev_in(ev_in),
    .axis_start(axis_start), .axis_stop(axis_stop), .act_move(act_move),
    .act_arc(act_arc), .act_mode(act_mode), .evt_pins(evt_pins)
);
`default_nettype wire

// ### mss_pulse_model.sv
/*
 * Pulse generator stand-in: answers each launched real step with one done pulse.
 * Assumes launches arrive as one-cycle pulses on clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module mss_pulse_model #(
    parameter int LAT = 6
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Launch and pace
    input  wire logic [3:0] axis_start,
    input  wire logic       slow,
    // Step completion
    output logic [3:0]      done_in
);
    int cnt[4];

    // Axis n runs LAT+4n cycles so stops come staggered; slow stretches steps
    always_ff @(posedge clk_sys) begin
        for (int n = 0; n < 4; n++) begin
            done_in[n] <= !rst && cnt[n] == 1;
            if (rst) cnt[n] <= 0;
            else if (axis_start[n]) cnt[n] <= LAT + 4 * n + (slow ? 60 : 0);
            else if (cnt[n] != 0) cnt[n] <= cnt[n] - 1;
        end
    end
endmodule // mss_pulse_model
`default_nettype wire

// ### multi_axis_sync_start_sequencer_test.sv
/*
 * Self-checking bench of mss_top: APB host tasks and one task per scenario.
 * Assumes mss_pulse_model answers launches; events are driven here.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mss_map.svh"
module multi_axis_sync_start_sequencer_test;
    logic          clk_sys, rst, psel, penable, pwrite, pready, pslverr, slow;
    logic [31:0]   paddr, pwdata, prdata;
    logic [3:0]    done_in, axis_start, axis_stop, evt_irq;
    logic [35:0]   ev_in, evt_pins;
    logic [127:0]  act_move, act_arc, act_mode;
    int            errors, checked;
    int            ns[4] = '{0, 0, 0, 0};
    int            ne[4] = '{0, 0, 0, 0};
    logic [31:0]   q;
    logic          e;

    mss_top dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .done_in(done_in), .ev_in(ev_in), .axis_start(axis_start), .axis_stop(axis_stop),
        .act_move(act_move), .act_arc(act_arc), .act_mode(act_mode), .evt_pins(evt_pins),
        .evt_irq(evt_irq));
    mss_pulse_model #(.LAT(6)) u_gen (.clk_sys(clk_sys), .rst(rst), .axis_start(axis_start),
        .slow(slow), .done_in(done_in));

    // Count launches and stops off the sampling edge to stay race free
    always @(negedge clk_sys) begin
        for (int n = 0; n < 4; n++) begin
            if (axis_start[n] === 1'b1) ns[n]++;
            if (axis_stop[n] === 1'b1) ne[n]++;
        end
    end

    function automatic logic [31:0] ra(input int ax, input logic [5:0] off);
        return 32'(ax * 64) + {26'h0, off};
    endfunction

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            errors++;
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk("write error flag", 32'h0, {31'h0, e});
    endtask

    task automatic rd(input string w, input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(w, exp, q);
    endtask

    task automatic step(input int ax, input logic [31:0] mv, input logic [31:0] md);
        wr(ra(ax, `MSS_OFF_MOVE), mv);
        wr(ra(ax, `MSS_OFF_MODE), md);
    endtask

    task automatic wait_cnt(input int ax, input bit st, input int tgt);
        int k;
        k = 0;
        while ((st ? ne[ax] : ns[ax]) < tgt && k < 300) begin
            @(posedge clk_sys);
            k++;
        end
        if (k >= 300) begin
            chk("axis event count", 32'(tgt), 32'(st ? ne[ax] : ns[ax]));
            report_and_stop();
        end
    endtask

    task automatic pulse(input int b);
        @(posedge clk_sys);
        ev_in[b] <= 1'b1;
        @(posedge clk_sys);
        ev_in[b] <= 1'b0;
    endtask

    task automatic t_regs;
        rd("mode at reset", ra(1, `MSS_OFF_MODE), 32'h0);
        rd("status at reset", ra(2, `MSS_OFF_STATUS), 32'h0);
        wr(ra(3, `MSS_OFF_ARC), 32'h0000_1234);
        rd("arc readback", ra(3, `MSS_OFF_ARC), 32'h0000_1234);
        rd("unmapped data", 32'h0000_0020, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, e});
        rd("command reads zero", 32'(`MSS_ADDR_CMD), 32'h0);
    endtask

    task automatic t_chain;
        slow <= 1'b1;
        wr(ra(0, `MSS_OFF_ARC), 32'h0000_2710);
        step(0, 32'h2710, 32'h64);
        step(1, 32'h2710, 32'h64);
        wr(32'(`MSS_ADDR_CMD), 32'h0351);
        wait_cnt(0, 0, 1);
        chk("X arc active", 32'h2710, act_arc[31:0]);
        chk("Y kind", 32'h64, act_mode[63:32]);
        // Next step queued while the first still runs
        step(0, 32'h2710, 32'h61);
        step(1, 32'h1388, 32'h61);
        wr(32'(`MSS_ADDR_CMD), 32'h0351);
        rd("X waits previous", ra(0, `MSS_OFF_STATUS), 32'h2);
        chk("no early launch", 32'h1, 32'(ns[0]));
        wait_cnt(0, 0, 2);
        chk("X linear", 32'h61, act_mode[31:0]);
        chk("X arc cleared", 32'h0, act_arc[31:0]);
        wait_cnt(1, 0, 2);
        chk("Y chained move", 32'h1388, act_move[63:32]);
        slow <= 1'b0;
        wait_cnt(1, 1, 2);
    endtask

    task automatic t_stop;
        int x, y, z;
        x = ne[0];
        y = ne[1];
        z = ne[2];
        step(2, 32'h0, 32'h003C_0041);
        step(0, 32'h10, 32'h61);
        step(1, 32'h10, 32'h61);
        wr(32'(`MSS_ADDR_CMD), 32'h0751);
        rd("Z waits stops", ra(2, `MSS_OFF_STATUS), 32'h4);
        wait_cnt(0, 1, x + 1);
        repeat (2) @(posedge clk_sys);
        chk("Z holds for Y", 32'(z), 32'(ne[2]));
        wait_cnt(2, 1, z + 1);
        chk("Y stopped first", 32'(y + 1), 32'(ne[1]));
        chk("Z no launch", 32'h0, 32'(ns[2]));
        chk("U untouched", 32'h0, 32'(ns[3] + ne[3]));
        rd("U idle", ra(3, `MSS_OFF_STATUS), 32'h0);
    endtask

    task automatic t_sync;
        int s;
        s = ns[0];
        wr(ra(0, `MSS_OFF_ENV5), 32'h0010_0000);
        wr(ra(1, `MSS_OFF_ENV5), 32'h0009_0000);
        wr(ra(1, `MSS_OFF_IRQEN), 32'h0000_0020);
        step(0, 32'h10, 32'h0008_0061);
        wr(32'(`MSS_ADDR_CMD), 32'h0151);
        rd("X waits sync", ra(0, `MSS_OFF_STATUS), 32'h3);
        pulse(9);
        repeat (4) @(posedge clk_sys);
        chk("other event ignored", 32'(s), 32'(ns[0]));
        pulse(10);
        wait_cnt(0, 0, s + 1);
        rd("cause latched", ra(1, `MSS_OFF_CAUSE), 32'h0000_0020);
        chk("event irq", 32'h1, {31'h0, evt_irq[1]});
        // Comparator 1 of Y now drives the sync; mode of X stays queued as before
        wr(ra(1, `MSS_OFF_ENV5), 32'h0001_0000);
        wr(32'(`MSS_ADDR_CMD), 32'h0151);
        pulse(13);
        wait_cnt(0, 0, s + 2);
    endtask

    task automatic t_own;
        int s;
        s = ns[0];
        slow <= 1'b1;
        wr(ra(0, `MSS_OFF_ENV2), 32'h2000_0000);
        step(0, 32'h10, 32'h61);
        wr(32'(`MSS_ADDR_CMD), 32'h0151);
        step(0, 32'h10, 32'h001C_0061);
        wr(32'(`MSS_ADDR_CMD), 32'h0151);
        wait_cnt(0, 0, s + 2);
        chk("X relaunched", 32'h001C_0061, act_mode[31:0]);
        slow <= 1'b0;
    endtask

    // Free running clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, slow} = 4'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        ev_in = 36'h0;
        errors = 0;
        checked = 0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_chain();
        t_stop();
        t_sync();
        t_own();
        report_and_stop();
    end
endmodule // multi_axis_sync_start_sequencer_test
`default_nettype wire
